/* design/agd_cfg.svh */
`ifndef AGD_CFG_SVH
`define AGD_CFG_SVH

`define AGD_GROUPS 4
`define AGD_GIDX_W 2
`define AGD_GREF_W 4
`define AGD_AXES 8
`define AGD_INT_W 3

`define AGD_ST_OFF 8'h00
`define AGD_ST_HALT 8'h01
`define AGD_ST_IDLE 8'h04
`define AGD_ST_INVALID 8'hFF
`define AGD_RST_GRP_STATE 8'h00

`define AGD_CODE_NONE 16'h0000
`define AGD_CODE_BAD_STATE 16'h1A97
`define AGD_CODE_PARAM 16'h1D81
`define AGD_CODE_RANGE 16'h3402

`define AGD_OFF_CTRL 8'h00
`define AGD_OFF_GREF 8'h04
`define AGD_OFF_STATUS 8'h08
`define AGD_OFF_INT_STAT 8'h0C
`define AGD_OFF_INT_EN 8'h10
`define AGD_OFF_INT_CLR 8'h14
`define AGD_OFF_GRP_SEL 8'h18
`define AGD_OFF_GRP_CFG 8'h1C
`define AGD_OFF_AXIS_FLAGS 8'h20
`define AGD_OFF_INIT_CODE 8'h24

`define AGD_CTRL_EXEC 0
`define AGD_CFG_MEMB_LSB 8
`define AGD_STAT_CODE_LSB 16
`define AGD_INT_DONE 0
`define AGD_INT_ERR 1
`define AGD_INT_INIT 2

`endif

/* design/agd_pkg.sv */
`include "agd_cfg.svh"
package agd_pkg;

  typedef enum logic [3:0] {
    AGD_IDLE = 4'h1,
    AGD_WAIT = 4'h2,
    AGD_FIN  = 4'h4,
    AGD_FAIL = 4'h8
  } agd_fsm_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } agd_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } agd_wb_rsp_t;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        error;
    logic [15:0] code;
  } agd_cmd_stat_t;

  typedef struct packed {
    logic [7:0]           state;
    logic [`AGD_AXES-1:0] members;
    logic                 off;
  } agd_cell_t;

  typedef struct packed {
    agd_fsm_t               fsm;
    logic                   exec;
    logic                   exec_q;
    logic [`AGD_GREF_W-1:0] gref;
    agd_cmd_stat_t          cmd;
    logic [15:0]            init_code;
    logic [`AGD_INT_W-1:0]  int_stat;
    logic [`AGD_INT_W-1:0]  int_en;
    logic [`AGD_GIDX_W-1:0] grp_sel;
    logic [`AGD_AXES-1:0]   axis_flags;
    logic [`AGD_GROUPS-1:0] refresh;
    agd_wb_rsp_t            rsp;
    logic                   irq;
  } agd_top_t;

endpackage

/* design/agd_group_cell.sv */
`timescale 1ns/1ps
`include "agd_cfg.svh"
module agd_group_cell
  import agd_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 load_i,
  input  wire logic [7:0]           load_state_i,
  input  wire logic [`AGD_AXES-1:0] load_members_i,
  input  wire logic                 param_fault_i,
  input  wire logic [`AGD_AXES-1:0] axis_fault_i,
  input  wire logic                 disable_i,
  input  wire logic                 moving_i,
  output logic [7:0]                state_o,
  output logic [`AGD_AXES-1:0]      members_o,
  output logic                      off_o
);

  agd_cell_t r;
  agd_cell_t n;
  logic      member_fault;
  logic      can_disable;

  assign member_fault = |(axis_fault_i & r.members);
  assign can_disable  = (r.state == `AGD_ST_IDLE) || (r.state == `AGD_ST_HALT);

  always_comb begin
    n     = r;
    n.off = 1'b0;
    if (param_fault_i) begin
      n.state = `AGD_ST_INVALID;
    end else if (load_i) begin
      n.state   = load_state_i;
      n.members = load_members_i;
    end else if (disable_i && !moving_i && can_disable) begin
      // a group still coasting to a stop keeps its state until it halts
      n.state = `AGD_ST_OFF;
      n.off   = 1'b1;
    end else if (member_fault && r.state != `AGD_ST_OFF && r.state != `AGD_ST_INVALID) begin
      n.state = `AGD_ST_HALT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.state <= `AGD_RST_GRP_STATE;
    end else begin
      r <= n;
    end
  end

  assign state_o   = r.state;
  assign members_o = r.members;
  assign off_o     = r.off;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  init_fault_a: assert property (param_fault_i |=> state_o == `AGD_ST_INVALID)
    else $error("parameter fault did not make the group invalid");

  stop_wait_a: assert property (
    disable_i && moving_i && can_disable && !load_i && !param_fault_i |=> state_o != `AGD_ST_OFF)
    else $error("group disabled while still moving");

  member_halt_a: assert property (
    member_fault && r.state == `AGD_ST_IDLE && !param_fault_i && !load_i && !disable_i
    |=> state_o == `AGD_ST_HALT)
    else $error("member axis fault did not halt the group");

endmodule

/* design/agd_top.sv */
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "agd_cfg.svh"
module agd_top
  import agd_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire agd_wb_req_t            wb_req_i,
  output agd_wb_rsp_t                 wb_rsp_o,
  input  wire logic [`AGD_GROUPS-1:0] grp_moving_i,
  input  wire logic [`AGD_GROUPS-1:0] grp_param_fault_i,
  input  wire logic [`AGD_AXES-1:0]   axis_fault_i,
  output agd_cmd_stat_t               cmd_stat_o,
  output logic [`AGD_AXES-1:0]        axis_in_group_flag_o,
  output logic [`AGD_GROUPS-1:0]      monitor_refresh_o,
  output logic                        irq_o
);

  agd_top_t                           r;
  agd_top_t                           n;

  logic [`AGD_GROUPS-1:0][7:0]          cell_state;
  logic [`AGD_GROUPS-1:0][`AGD_AXES-1:0] cell_members;
  logic [`AGD_GROUPS-1:0]               cell_off;
  logic [`AGD_GROUPS-1:0]               grp_load;
  logic [`AGD_GROUPS-1:0]               grp_disable;
  logic [`AGD_GROUPS-1:0]               cell_invalid;

  logic                               wb_hit;
  logic                               wr_en;
  logic                               rd_en;
  logic                               cfg_wr;
  logic [31:0]                        cfg_word;
  logic                               exec_rise;
  logic                               gref_ok;
  logic [`AGD_GIDX_W-1:0]             gidx;
  logic [7:0]                         sel_state;

  function automatic logic [31:0] wmerge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  sel
  );
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // a new request is taken only while no ack is out, so each access gets one ack
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !r.rsp.ack;
  assign wr_en  = wb_hit && wb_req_i.we;
  assign rd_en  = wb_hit && !wb_req_i.we;
  assign cfg_wr = wr_en && (wb_req_i.adr == `AGD_OFF_GRP_CFG);

  assign cfg_word = wmerge({16'h0000, cell_members[r.grp_sel], cell_state[r.grp_sel]},
                           wb_req_i.dat, wb_req_i.sel);

  assign exec_rise = r.exec && !r.exec_q;
  assign gref_ok   = r.gref < `AGD_GREF_W'(`AGD_GROUPS);
  assign gidx      = r.gref[`AGD_GIDX_W-1:0];
  assign sel_state = cell_state[gidx];

  genvar g;
  generate
    for (g = 0; g < `AGD_GROUPS; g++) begin : gen_cell
      assign grp_load[g]    = cfg_wr && (r.grp_sel == `AGD_GIDX_W'(g));
      // the disable request is held for the whole wait; the cell acts once motion ends
      assign grp_disable[g] = (r.fsm == AGD_WAIT) && (r.gref == `AGD_GREF_W'(g));
      assign cell_invalid[g] = cell_state[g] == `AGD_ST_INVALID;

      agd_group_cell u_cell (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .load_i         (grp_load[g]),
        .load_state_i   (cfg_word[7:0]),
        .load_members_i (cfg_word[`AGD_CFG_MEMB_LSB +: `AGD_AXES]),
        .param_fault_i  (grp_param_fault_i[g]),
        .axis_fault_i   (axis_fault_i),
        .disable_i      (grp_disable[g]),
        .moving_i       (grp_moving_i[g]),
        .state_o        (cell_state[g]),
        .members_o      (cell_members[g]),
        .off_o          (cell_off[g])
      );
    end
  endgenerate

  always_comb begin
    logic [31:0]           w;
    logic [`AGD_INT_W-1:0] clr;
    logic [`AGD_INT_W-1:0] ev;
    w   = wmerge(32'h0000_0000, wb_req_i.dat, wb_req_i.sel);
    clr = '0;
    ev  = '0;
    n   = r;

    n.exec_q   = r.exec;
    n.rsp.ack  = wb_hit;
    n.rsp.dat  = 32'h0000_0000;

    for (int i = 0; i < `AGD_GROUPS; i++) begin
      n.refresh[i] = cell_state[i] != `AGD_ST_INVALID;
    end

    if (wr_en) begin
      case (wb_req_i.adr)
        `AGD_OFF_CTRL: begin
          if (wb_req_i.sel[0]) begin
            n.exec = w[`AGD_CTRL_EXEC];
          end
        end
        `AGD_OFF_GREF: begin
          if (wb_req_i.sel[0]) begin
            n.gref = w[`AGD_GREF_W-1:0];
          end
        end
        `AGD_OFF_INT_EN: begin
          if (wb_req_i.sel[0]) begin
            n.int_en = w[`AGD_INT_W-1:0];
          end
        end
        `AGD_OFF_INT_CLR: begin
          clr = w[`AGD_INT_W-1:0];
        end
        `AGD_OFF_GRP_SEL: begin
          if (wb_req_i.sel[0]) begin
            n.grp_sel = w[`AGD_GIDX_W-1:0];
          end
        end
        `AGD_OFF_GRP_CFG: begin
          // stands in for the enable path: a group loaded as standby claims its axes
          if (cfg_word[7:0] == `AGD_ST_IDLE) begin
            n.axis_flags = r.axis_flags | cfg_word[`AGD_CFG_MEMB_LSB +: `AGD_AXES];
          end
        end
        default: begin
        end
      endcase
    end

    if (rd_en) begin
      case (wb_req_i.adr)
        `AGD_OFF_CTRL: n.rsp.dat = {31'h0000_0000, r.exec};
        `AGD_OFF_GREF: n.rsp.dat = {28'h000_0000, r.gref};
        `AGD_OFF_STATUS: begin
          n.rsp.dat = {r.cmd.code, 13'h0000, r.cmd.error, r.cmd.done, r.cmd.busy};
        end
        `AGD_OFF_INT_STAT: n.rsp.dat = {29'h0000_0000, r.int_stat};
        `AGD_OFF_INT_EN: n.rsp.dat = {29'h0000_0000, r.int_en};
        `AGD_OFF_GRP_SEL: n.rsp.dat = {30'h0000_0000, r.grp_sel};
        `AGD_OFF_GRP_CFG: begin
          n.rsp.dat = {16'h0000, cell_members[r.grp_sel], cell_state[r.grp_sel]};
        end
        `AGD_OFF_AXIS_FLAGS: n.rsp.dat = {24'h00_0000, r.axis_flags};
        `AGD_OFF_INIT_CODE: n.rsp.dat = {16'h0000, r.init_code};
        default: n.rsp.dat = 32'h0000_0000;
      endcase
    end

    for (int i = 0; i < `AGD_GROUPS; i++) begin
      if (cell_off[i]) begin
        n.axis_flags = n.axis_flags & ~cell_members[i];
      end
    end

    if (|grp_param_fault_i) begin
      n.init_code = `AGD_CODE_PARAM;
    end

    case (r.fsm)
      AGD_IDLE: begin
        if (exec_rise) begin
          if (!gref_ok) begin
            n.fsm        = AGD_FAIL;
            n.cmd.error  = 1'b1;
            n.cmd.code   = `AGD_CODE_RANGE;
          end else if (sel_state == `AGD_ST_OFF) begin
            n.fsm        = AGD_FIN;
            n.cmd.done   = 1'b1;
          end else if (sel_state == `AGD_ST_IDLE || sel_state == `AGD_ST_HALT) begin
            n.fsm        = AGD_WAIT;
            n.cmd.busy   = 1'b1;
          end else begin
            n.fsm        = AGD_FAIL;
            n.cmd.error  = 1'b1;
            n.cmd.code   = `AGD_CODE_BAD_STATE;
          end
        end
      end
      AGD_WAIT: begin
        if (sel_state == `AGD_ST_OFF) begin
          n.fsm      = AGD_FIN;
          n.cmd.busy = 1'b0;
          n.cmd.done = 1'b1;
        end
      end
      AGD_FIN, AGD_FAIL: begin
        if (!r.exec) begin
          n.fsm = AGD_IDLE;
          n.cmd = '{busy: 1'b0, done: 1'b0, error: 1'b0, code: `AGD_CODE_NONE};
        end
      end
      default: begin
        n.fsm = AGD_IDLE;
        n.cmd = '{busy: 1'b0, done: 1'b0, error: 1'b0, code: `AGD_CODE_NONE};
      end
    endcase

    if (n.cmd.error) begin
      n.cmd.busy = 1'b0;
    end

    ev[`AGD_INT_DONE] = n.cmd.done && !r.cmd.done;
    ev[`AGD_INT_ERR]  = n.cmd.error && !r.cmd.error;
    ev[`AGD_INT_INIT] = |grp_param_fault_i;
    // clear first, then set, so an event in the clearing cycle survives
    n.int_stat = (r.int_stat & ~clr) | ev;
    n.irq      = |(n.int_stat & n.int_en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r         <= '0;
      r.fsm     <= AGD_IDLE;
      r.refresh <= '1;
    end else begin
      r <= n;
    end
  end

  assign wb_rsp_o             = r.rsp;
  assign cmd_stat_o           = r.cmd;
  assign axis_in_group_flag_o = r.axis_flags;
  assign monitor_refresh_o    = r.refresh;
  assign irq_o                = r.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  busy_start_a: assert property (
    r.fsm == AGD_IDLE && exec_rise && gref_ok &&
    (sel_state == `AGD_ST_IDLE || sel_state == `AGD_ST_HALT)
    |=> cmd_stat_o.busy && !cmd_stat_o.done)
    else $error("accepted command did not raise busy");

  done_busy_a: assert property ($rose(cmd_stat_o.done) |-> !cmd_stat_o.busy && !cmd_stat_o.error)
    else $error("done raised while busy or error");

  done_off_a: assert property ($rose(cmd_stat_o.done) |-> cell_state[gidx] == `AGD_ST_OFF)
    else $error("done raised before group reached disabled");

  err_code_a: assert property ($rose(cmd_stat_o.error) |-> cmd_stat_o.code != `AGD_CODE_NONE)
    else $error("error raised without a failure code");

  code_zero_a: assert property (!cmd_stat_o.error |-> cmd_stat_o.code == `AGD_CODE_NONE)
    else $error("failure code nonzero without error");

  bad_state_a: assert property (
    r.fsm == AGD_IDLE && exec_rise && gref_ok && sel_state != `AGD_ST_OFF &&
    sel_state != `AGD_ST_IDLE && sel_state != `AGD_ST_HALT
    |=> cmd_stat_o.error && cmd_stat_o.code == `AGD_CODE_BAD_STATE && r.fsm == AGD_FAIL)
    else $error("bad group state not refused with its code");

  flag_clear_a: assert property (
    r.fsm == AGD_WAIT && cell_off[gidx] && !cfg_wr
    |=> (axis_in_group_flag_o & $past(cell_members[gidx])) == '0)
    else $error("member in-group flags not cleared");

  already_off_a: assert property (
    r.fsm == AGD_IDLE && exec_rise && gref_ok && sel_state == `AGD_ST_OFF
    |=> cmd_stat_o.done && !cmd_stat_o.error && !cmd_stat_o.busy)
    else $error("disabled group did not complete at once");

  refresh_stop_a: assert property (monitor_refresh_o == ~$past(cell_invalid))
    else $error("monitor refresh does not follow group validity");

  range_err_a: assert property (
    r.fsm == AGD_IDLE && exec_rise && !gref_ok
    |=> cmd_stat_o.error && cmd_stat_o.code == `AGD_CODE_RANGE && !cmd_stat_o.busy)
    else $error("out of range group not refused");

  exec_clear_a: assert property (
    (r.fsm == AGD_FIN || r.fsm == AGD_FAIL) && !r.exec
    |=> !cmd_stat_o.done && !cmd_stat_o.error && cmd_stat_o.code == `AGD_CODE_NONE ##1 r.fsm == AGD_IDLE)
    else $error("outputs not cleared after execute fell");

  ack_pulse_a: assert property (
    wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("bus ack stood for more than one cycle");

  ack_taken_a: assert property (
    wb_hit |=> wb_rsp_o.ack)
    else $error("accepted bus request got no ack");

  dat_idle_a: assert property (
    !wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0000_0000)
    else $error("read data driven without ack");

  cmd_idle_a: assert property (
    r.fsm == AGD_IDLE
    |-> !cmd_stat_o.busy && !cmd_stat_o.done && !cmd_stat_o.error && cmd_stat_o.code == `AGD_CODE_NONE)
    else $error("idle command with a flag or code standing");

  wait_busy_a: assert property (
    r.fsm == AGD_WAIT |-> cmd_stat_o.busy && !cmd_stat_o.done && !cmd_stat_o.error)
    else $error("busy not standing while the disable is pending");

  busy_legal_a: assert property (
    $rose(cmd_stat_o.busy) |-> $past(sel_state) == `AGD_ST_IDLE || $past(sel_state) == `AGD_ST_HALT)
    else $error("command accepted outside standby or error-stop");

  done_alone_a: assert property (
    cmd_stat_o.done |-> !cmd_stat_o.busy && !cmd_stat_o.error)
    else $error("done standing together with busy or error");

  err_alone_a: assert property (
    cmd_stat_o.error |-> !cmd_stat_o.busy && !cmd_stat_o.done)
    else $error("error standing together with busy or done");

  err_known_a: assert property (
    cmd_stat_o.error |-> cmd_stat_o.code == `AGD_CODE_BAD_STATE || cmd_stat_o.code == `AGD_CODE_RANGE)
    else $error("error reported with an unknown failure code");

  fail_flag_a: assert property (
    r.fsm == AGD_FAIL |-> cmd_stat_o.error)
    else $error("failed command without error flag");

  result_hold_a: assert property (
    (r.fsm == AGD_FIN || r.fsm == AGD_FAIL) && r.exec |=> $stable(cmd_stat_o))
    else $error("result changed while execute still high");

  halt_wait_a: assert property (
    r.fsm == AGD_WAIT && sel_state != `AGD_ST_OFF && grp_moving_i[gidx] && !cfg_wr
    |-> ##2 !cmd_stat_o.done)
    else $error("done given while the group was still moving");

  init_code_a: assert property (
    (|grp_param_fault_i) |=> r.init_code == `AGD_CODE_PARAM)
    else $error("parameter fault did not load its code");

  init_event_a: assert property (
    (|grp_param_fault_i) |=> r.int_stat[`AGD_INT_INIT])
    else $error("parameter fault event lost");

  irq_err_a: assert property (
    $rose(r.int_stat[`AGD_INT_ERR]) && r.int_en[`AGD_INT_ERR] |-> irq_o)
    else $error("enabled error event did not raise the interrupt");

endmodule

/* testbench/agd_cpu_model.sv */
`timescale 1ns/1ps
`include "agd_cfg.svh"
module agd_cpu_model
  import agd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire agd_wb_rsp_t wb_rsp_i,
  output agd_wb_req_t      wb_req_o,
  output logic             hung_o
);
  initial begin
    wb_req_o = '0;
    hung_o   = 1'b0;
  end

  // one classic cycle; request held until ack is seen at a rising edge
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp_i.ack !== 1'b1 && n < 100);
    q = wb_rsp_i.dat;
    if (n >= 100) hung_o <= 1'b1;
    wb_req_o <= '0;
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, q);
  endtask

  task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(1'b0, a, 32'h0000_0000, q);
  endtask

  // group number goes in before the execute bit rises
  task automatic issue(input logic [3:0] grp);
    wb_write(`AGD_OFF_GREF, {28'h0, grp});
    wb_write(`AGD_OFF_CTRL, 32'h0000_0001);
  endtask
endmodule

/* testbench/tb_axes_group_disable_cmd.sv */
`timescale 1ns/1ps
`include "agd_cfg.svh"
module tb_axes_group_disable_cmd;
  import agd_pkg::*;
  logic                   clk_i;
  logic                   rst_i;
  agd_wb_req_t            wb_req;
  agd_wb_rsp_t            wb_rsp;
  logic [`AGD_GROUPS-1:0] moving;
  logic [`AGD_GROUPS-1:0] pfault;
  logic [`AGD_AXES-1:0]   afault;
  logic [`AGD_AXES-1:0]   flags;
  logic [`AGD_GROUPS-1:0] refresh;
  agd_cmd_stat_t          cmd_stat;
  logic                   irq;
  logic                   hung;
  logic [31:0]            rd;
  int                     errors;
  int                     n_compared;

  agd_top i_dut (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .wb_req_i             (wb_req),
    .wb_rsp_o             (wb_rsp),
    .grp_moving_i         (moving),
    .grp_param_fault_i    (pfault),
    .axis_fault_i         (afault),
    .cmd_stat_o           (cmd_stat),
    .axis_in_group_flag_o (flags),
    .monitor_refresh_o    (refresh),
    .irq_o                (irq)
  );

  agd_cpu_model i_cpu (
    .clk_i    (clk_i),
    .wb_rsp_i (wb_rsp),
    .wb_req_o (wb_req),
    .hung_o   (hung)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    i_cpu.wb_read(a, rd);
    chk(rd, exp);
  endtask

  task automatic cfg(input logic [1:0] grp, input logic [31:0] v);
    i_cpu.wb_write(`AGD_OFF_GRP_SEL, {30'h0, grp});
    i_cpu.wb_write(`AGD_OFF_GRP_CFG, v);
  endtask

  // poll until done or error; busy alone is not an end
  task automatic wait_end();
    int n;
    n = 0;
    do begin
      i_cpu.wb_read(`AGD_OFF_STATUS, rd);
      n++;
    end while (rd[2:1] == 2'b00 && n < 50);
    if (n >= 50) begin
      errors++;
      conclude();
    end
  endtask

  task automatic cmd(input logic [3:0] grp, input logic [31:0] exp);
    i_cpu.issue(grp);
    wait_end();
    chk(rd, exp);
    i_cpu.wb_write(`AGD_OFF_CTRL, 32'h0000_0000);
    rchk(`AGD_OFF_STATUS, 32'h0000_0000);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    conclude();
  end

  always @(posedge clk_i) begin
    if (hung === 1'b1) begin
      errors++;
      conclude();
    end
  end

  initial begin
    errors = 0;
    n_compared = 0;
    rst_i = 1'b1;
    moving = '0;
    pfault = '0;
    afault = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({13'h0, cmd_stat}, 32'h0000_0000);
    rchk(`AGD_OFF_STATUS, 32'h0000_0000);
    chk({28'h0, refresh}, 32'h0000_000F);
    rchk(`AGD_OFF_INIT_CODE, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    i_cpu.wb_write(8'h40, 32'h0000_FFFF);
    i_cpu.wb_write(`AGD_OFF_INT_EN, 32'h0000_0003);
    cmd(4'h2, 32'h0000_0002);
    rchk(`AGD_OFF_INT_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    i_cpu.wb_write(`AGD_OFF_INT_CLR, 32'h0000_0007);
    rchk(`AGD_OFF_INT_STAT, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    // done events masked from here on
    i_cpu.wb_write(`AGD_OFF_INT_EN, 32'h0000_0002);
    cfg(2'h0, 32'h0000_0304);
    chk({24'h0, flags}, 32'h0000_0003);
    cmd(4'h0, 32'h0000_0002);
    chk({24'h0, flags}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    cfg(2'h1, 32'h0000_0C04);
    afault <= 8'h04;
    @(posedge clk_i);
    afault <= 8'h00;
    rchk(`AGD_OFF_GRP_CFG, 32'h0000_0C01);
    moving <= 4'h2;
    i_cpu.issue(4'h1);
    repeat (10) @(posedge clk_i);
    chk({13'h0, cmd_stat}, 32'h0004_0000);
    chk({24'h0, flags}, 32'h0000_000C);
    moving <= 4'h0;
    wait_end();
    chk(rd, 32'h0000_0002);
    chk({24'h0, flags}, 32'h0000_0000);
    i_cpu.wb_write(`AGD_OFF_CTRL, 32'h0000_0000);
    cfg(2'h3, 32'h0000_0002);
    cmd(4'h3, 32'h1A97_0004);
    chk({31'h0, irq}, 32'h0000_0001);
    i_cpu.wb_write(`AGD_OFF_INT_CLR, 32'h0000_0007);
    cmd(4'h5, 32'h3402_0004);
    rchk(`AGD_OFF_GREF, 32'h0000_0005);
    pfault <= 4'h8;
    @(posedge clk_i);
    pfault <= 4'h0;
    rchk(`AGD_OFF_INIT_CODE, 32'h0000_1D81);
    rchk(`AGD_OFF_INT_STAT, 32'h0000_0006);
    rchk(`AGD_OFF_GRP_CFG, 32'h0000_00FF);
    chk({28'h0, refresh}, 32'h0000_0007);
    cmd(4'h3, 32'h1A97_0004);
    conclude();
  end
endmodule
